// File: nvcr_ctrl_target.sv
// Control-register target of a serial nonvolatile memory, I2C side
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Writes store from given address, then advance
// - Non-writable data byte: NACK, ignore rest
// - Command write keeps counter; reads restart zero
// - Unknown register address on write: NACK
// - Locked: only command and control writable
// - Refused write leaves last acknowledged address
// - Read-direction target address starts current read
// - Reads wrap to zero, skip command
// - Read from command location starts zero
// - Unknown address before random read: NACK
// - Eight plain serial bytes, no checksum
// - Serial bytes reset to zero
// - Serial image offered to store logic
// - Lock set: serial writes NACKed, unchanged
// - Lock and serial zero unless recalled
// - Serial reads return current values always
// - Read-only 32-bit identification code fields
// - Maker field: bank then number
// - Busy executing command: NACK target address
// - Any command byte acknowledged, rest outside
// - Byte takes effect only on bit eight
module nvcr_ctrl_target
    import nvcr_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = 7'h50,
    // Identification values below are arbitrary
    parameter logic [2:0] MAKER_BANK = 3'h0,
    parameter logic [7:0] MAKER_NUM = 8'h5A,
    parameter logic [13:0] PART_CODE = 14'h0123,
    parameter logic [3:0] CAPACITY_CODE = 4'h2,
    parameter logic [2:0] DIE_REV = 3'h0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // I2C pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Command execution
    output logic [7:0] cmd_byte,
    output logic cmd_valid,
    input wire logic cmd_busy,
    // Nonvolatile image
    input wire logic recall_valid,
    input wire logic [7:0] recall_mem_ctrl,
    input wire logic [63:0] recall_serial,
    output logic [7:0] mem_ctrl_image,
    output logic [63:0] serial_image,
    output logic serial_lock_bit
);

    // ********************************************************************
    // Identification code
    // ********************************************************************
    localparam logic [10:0] MAKER_CODE_FIELD =
        {MAKER_BANK, MAKER_NUM};
    localparam logic [31:0] ID_CODE =
        (32'(MAKER_CODE_FIELD) << NVCR_ID_MAKER_POS) |
        (32'(PART_CODE) << NVCR_ID_PART_POS) |
        (32'(CAPACITY_CODE) << NVCR_ID_CAP_POS) |
        (32'(DIE_REV) << NVCR_ID_REV_POS);

    // Byte selection below serves exactly four identification bytes
    if (NVCR_OFS_ID_LAST - NVCR_OFS_ID_FIRST != 8'h03) begin : g_bad_id
        $error("Identification window must span four bytes");
    end

    // ********************************************************************
    // Storage
    // ********************************************************************
    logic [7:0] mem_ctrl_q;
    logic [7:0] serial_q [NVCR_SERIAL_BYTES];
    logic lock;

    assign lock = mem_ctrl_q[NVCR_LOCK_BIT];

    // ********************************************************************
    // Map decoding
    // ********************************************************************
    function automatic logic is_readable(input logic [7:0] a);
        is_readable = (a <= NVCR_OFS_LAST_READABLE);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = is_readable(a) || (a == NVCR_OFS_CMD);
    endfunction

    function automatic logic is_writable(input logic [7:0] a,
                                         input logic locked);
        logic serial;
        serial = (a >= NVCR_OFS_SERIAL_FIRST) &&
                 (a <= NVCR_OFS_SERIAL_LAST);
        is_writable = (a == NVCR_OFS_CMD) || (a == NVCR_OFS_MEM_CTRL) ||
                      (serial && !locked);
    endfunction

    // Address of the byte actually served for a read
    function automatic logic [7:0] rd_start(input logic [7:0] a);
        rd_start = is_readable(a) ? a : NVCR_OFS_MEM_CTRL;
    endfunction

    function automatic logic [7:0] rd_next(input logic [7:0] a);
        rd_next = (a == NVCR_OFS_LAST_READABLE) ? NVCR_OFS_MEM_CTRL
                                                : 8'(a + 8'h01);
    endfunction

    function automatic logic [7:0] rd_data(input logic [7:0] a);
        logic [2:0] sidx;
        logic [1:0] iidx;
        sidx = 3'(a - NVCR_OFS_SERIAL_FIRST);
        iidx = 2'(NVCR_OFS_ID_LAST - a);
        if (a == NVCR_OFS_MEM_CTRL) begin
            rd_data = mem_ctrl_q;
        end else if (a <= NVCR_OFS_SERIAL_LAST) begin
            rd_data = serial_q[sidx];
        end else begin
            rd_data = 8'(ID_CODE >> {iidx, 3'b000});
        end
    endfunction

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    logic [2:0] scl_sync_q;
    logic [2:0] sda_sync_q;
    logic scl_f_q;
    logic sda_f_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_q <= 3'b111;
            sda_sync_q <= 3'b111;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_i};
            sda_sync_q <= {sda_sync_q[1:0], sda_i};
        end
    end

    // Filtered level changes only when stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            if (scl_sync_q[1] == scl_sync_q[2]) begin
                scl_f_q <= scl_sync_q[2];
            end
            if (sda_sync_q[1] == sda_sync_q[2]) begin
                sda_f_q <= sda_sync_q[2];
            end
        end
    end

    logic scl_new;
    logic sda_new;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_new = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2]
                                                      : scl_f_q;
    assign sda_new = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2]
                                                      : sda_f_q;
    assign scl_rise = scl_new && !scl_f_q;
    assign scl_fall = !scl_new && scl_f_q;
    assign start_cond = scl_f_q && scl_new && sda_f_q && !sda_new;
    assign stop_cond = scl_f_q && scl_new && !sda_f_q && sda_new;

    // ********************************************************************
    // Byte engine
    // ********************************************************************
    nvcr_state_t state_q;
    nvcr_state_t next_q;
    nvcr_state_t next_d;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic [7:0] tx_q;
    logic ack_q;
    logic ack_d;
    logic drive_low_q;
    logic [7:0] rx_byte;
    logic byte_done;
    logic wr_en;
    logic [7:0] ptr_d;
    logic [7:0] rd_addr;
    logic [7:0] rd_val;

    assign rx_byte = {shift_q[6:0], sda_f_q};
    // Effects only when the eighth bit is sampled
    assign byte_done = scl_rise && (bit_q == NVCR_BIT_LAST_DATA);
    assign rd_addr = rd_start(ptr_q);

    // Process form so register contents read inside the function count
    always_comb begin
        rd_val = rd_data(rd_addr);
    end

    // Decision taken at the eighth data bit
    always_comb begin
        ack_d = 1'b0;
        next_d = NVCR_ST_SKIP;
        wr_en = 1'b0;
        ptr_d = ptr_q;
        case (state_q)
            NVCR_ST_DEV: begin
                if (rx_byte[7:1] == TARGET_ADDR && !cmd_busy) begin
                    ack_d = 1'b1;
                    next_d = rx_byte[0] ? NVCR_ST_RD : NVCR_ST_ADDR;
                end
            end
            NVCR_ST_ADDR: begin
                // Single address byte; unmapped leaves counter as is
                if (is_mapped(rx_byte)) begin
                    ack_d = 1'b1;
                    next_d = NVCR_ST_WR;
                    ptr_d = rx_byte;
                end
            end
            NVCR_ST_WR: begin
                if (is_writable(ptr_q, lock)) begin
                    ack_d = 1'b1;
                    next_d = NVCR_ST_WR;
                    wr_en = 1'b1;
                    if (ptr_q != NVCR_OFS_CMD) begin
                        ptr_d = 8'(ptr_q + 8'h01);
                    end
                end
                // Refused: NACK, counter holds, rest skipped
            end
            default: begin
                ack_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= NVCR_ST_IDLE;
            next_q <= NVCR_ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ack_q <= 1'b0;
            ptr_q <= NVCR_RST_PTR;
            tx_q <= 8'h00;
            drive_low_q <= 1'b0;
        end else if (start_cond) begin
            state_q <= NVCR_ST_DEV;
            bit_q <= 4'h0;
            drive_low_q <= 1'b0;
        end else if (stop_cond) begin
            state_q <= NVCR_ST_IDLE;
            bit_q <= 4'h0;
            drive_low_q <= 1'b0;
        end else if (state_q != NVCR_ST_IDLE && state_q != NVCR_ST_SKIP) begin
            if (scl_rise) begin
                bit_q <= 4'(bit_q + 4'h1);
                shift_q <= rx_byte;
                if (byte_done && state_q != NVCR_ST_RD) begin
                    ack_q <= ack_d;
                    next_q <= next_d;
                    ptr_q <= ptr_d;
                end
                if (state_q == NVCR_ST_RD && bit_q == NVCR_BIT_ACK) begin
                    // Master ACK asks for another byte
                    next_q <= sda_f_q ? NVCR_ST_SKIP : NVCR_ST_RD;
                end
            end else if (scl_fall) begin
                if (bit_q == NVCR_BIT_END) begin
                    state_q <= next_q;
                    bit_q <= 4'h0;
                    drive_low_q <= 1'b0;
                    if (next_q == NVCR_ST_RD) begin
                        tx_q <= rd_val;
                        ptr_q <= rd_next(rd_addr);
                        drive_low_q <= !rd_val[7];
                    end
                end else if (bit_q == NVCR_BIT_ACK) begin
                    // Own ACK slot on receive, released on send
                    drive_low_q <= (state_q != NVCR_ST_RD) && ack_q;
                end else if (state_q == NVCR_ST_RD) begin
                    drive_low_q <= !tx_q[3'(4'h7 - bit_q)];
                end
            end
        end else begin
            drive_low_q <= 1'b0;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = drive_low_q;

    // ********************************************************************
    // Register writes and command hand-off
    // ********************************************************************
    logic [2:0] wr_sidx;

    assign wr_sidx = 3'(ptr_q - NVCR_OFS_SERIAL_FIRST);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ctrl_q <= NVCR_RST_MEM_CTRL;
            for (int i = 0; i < NVCR_SERIAL_BYTES; i++) begin
                serial_q[i] <= NVCR_RST_SERIAL;
            end
        end else if (byte_done && wr_en && state_q == NVCR_ST_WR &&
                     !start_cond && !stop_cond) begin
            if (ptr_q == NVCR_OFS_MEM_CTRL) begin
                mem_ctrl_q <= rx_byte;
            end else if (ptr_q != NVCR_OFS_CMD) begin
                serial_q[wr_sidx] <= rx_byte;
            end
        end else if (recall_valid) begin
            // Restores what a previous store captured
            mem_ctrl_q <= recall_mem_ctrl;
            for (int i = 0; i < NVCR_SERIAL_BYTES; i++) begin
                serial_q[i] <= recall_serial[8*i +: 8];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_byte <= 8'h00;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= 1'b0;
            if (byte_done && wr_en && state_q == NVCR_ST_WR &&
                ptr_q == NVCR_OFS_CMD && !start_cond && !stop_cond) begin
                // Decoding left to the executor; unknown ones are no-ops
                cmd_byte <= rx_byte;
                cmd_valid <= 1'b1;
            end
        end
    end

    // ********************************************************************
    // Image seen by store logic
    // ********************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ctrl_image <= NVCR_RST_MEM_CTRL;
            serial_image <= 64'h0000_0000_0000_0000;
            serial_lock_bit <= 1'b0;
        end else begin
            mem_ctrl_image <= mem_ctrl_q;
            serial_lock_bit <= lock;
            for (int i = 0; i < NVCR_SERIAL_BYTES; i++) begin
                serial_image[8*i +: 8] <= serial_q[i];
            end
        end
    end

endmodule // nvcr_ctrl_target

`default_nettype wire

// File: nvcr_ctrl_target_bench.sv
// Self-checking bench for the control-register target
`timescale 1ns/1ps
`default_nettype none
module nvcr_ctrl_target_bench
    import nvcr_pkg::*;
;
    // Identification values below are arbitrary
    localparam logic [6:0] TA = 7'h52;
    localparam logic [31:0] ID = {3'h1, 8'hA5, 14'h1234, 4'h3, 3'h2};
    localparam logic [63:0] SER = 64'h8877_6655_4433_2211;
    localparam int LIMIT = 80000;
    logic ref_clk, rst_n, scl, pull, sda, sda_o, sda_oe, cmd_valid, k;
    logic cmd_busy, recall_valid, serial_lock_bit;
    logic [7:0] cmd_byte, recall_mem_ctrl, mem_ctrl_image, d;
    logic [63:0] recall_serial, serial_image;
    logic [7:0] e[$];
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    int cmd_cnt = 0;
    int n0;

    // ********************************************************************
    // Wiring
    // ********************************************************************
    assign sda = !(pull || (sda_oe && sda_o == 1'b0));
    nvcr_ctrl_target #(.TARGET_ADDR(TA), .MAKER_BANK(ID[31:29]),
        .MAKER_NUM(ID[28:21]), .PART_CODE(ID[20:7]),
        .CAPACITY_CODE(ID[6:3]), .DIE_REV(ID[2:0])) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .cmd_byte(cmd_byte),
        .cmd_valid(cmd_valid), .cmd_busy(cmd_busy),
        .recall_valid(recall_valid), .recall_mem_ctrl(recall_mem_ctrl),
        .recall_serial(recall_serial), .mem_ctrl_image(mem_ctrl_image),
        .serial_image(serial_image), .serial_lock_bit(serial_lock_bit));
    nvcr_i2c_master mst (.ref_clk(ref_clk), .sda(sda), .scl(scl),
        .sda_pull(pull));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cmd_valid === 1'b1) cmd_cnt++;
        if (cycles == LIMIT) begin
            error_cnt++;
            complete_run();
        end
    end

    // ********************************************************************
    // Shared tasks
    // ********************************************************************
    task automatic complete_run;
        if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask
    task automatic head(input logic [7:0] a, output logic ack);
        mst.start();
        mst.wr_byte({TA, 1'b0}, ack);
        chk(ack, 1'b1);
        mst.wr_byte(a, ack);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v, logic exp);
        head(a, k);
        chk(k, 1'b1);
        mst.wr_byte(v, k);
        chk(k, exp);
        mst.stop();
    endtask
    task automatic rd_chk(input logic [7:0] q[$]);
        mst.start();
        mst.wr_byte({TA, 1'b1}, k);
        chk(k, 1'b1);
        foreach (q[i]) begin
            mst.rd_byte(i < q.size() - 1, d);
            chk(d, q[i]);
        end
        mst.stop();
    endtask
    task automatic rnd_chk(input logic [7:0] a, input logic [7:0] q[$]);
        head(a, k);
        chk(k, 1'b1);
        rd_chk(q);
    endtask

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic t_reset;
        chk(mem_ctrl_image, 8'h00);
        chk(serial_image, 64'h0);
        e = '{8'h00};
        repeat (8) e.push_back(8'h00);
        for (int i = 3; i >= 0; i--) e.push_back(ID[8*i +: 8]);
        e.push_back(8'h00);
        rnd_chk(NVCR_OFS_MEM_CTRL, e);
    endtask
    task automatic t_serial;
        head(NVCR_OFS_SERIAL_FIRST, k);
        for (int i = 1; i <= 8; i++) begin
            mst.wr_byte(8'(8'h11 * i), k);
            chk(k, 1'b1);
        end
        repeat (2) begin
            mst.wr_byte(8'h5A, k);
            chk(k, 1'b0);
        end
        mst.stop();
        chk(serial_image, SER);
        rd_chk('{ID[31:24]});
    endtask
    task automatic t_bad;
        for (int i = 0; i < 3; i++) begin
            head(i == 0 ? 8'h0D : i == 1 ? 8'hAB : 8'hFF, k);
            chk(k, 1'b0);
            mst.stop();
        end
        rd_chk('{ID[23:16]});
    endtask
    task automatic t_cmd;
        n0 = cmd_cnt;
        wr(NVCR_OFS_CMD, 8'h3C, 1'b1);
        chk(cmd_cnt - n0, 1);
        chk(cmd_byte, 8'h3C);
        rd_chk('{8'h00, 8'h11});
        rnd_chk(NVCR_OFS_CMD, '{8'h00, 8'h11});
    endtask
    task automatic t_lock;
        wr(NVCR_OFS_MEM_CTRL, 8'h01, 1'b1);
        chk(serial_lock_bit, 1'b1);
        wr(8'h03, 8'hEE, 1'b0);
        chk(serial_image, SER);
        rd_chk('{8'h33, 8'h44});
        rnd_chk(8'h03, '{8'h33});
        wr(NVCR_OFS_MEM_CTRL, 8'h00, 1'b1);
        wr(8'h03, 8'hEE, 1'b1);
        chk(serial_image, 64'h8877_6655_44EE_2211);
        // Stop on the seventh clock: byte must not land
        head(8'h02, k);
        for (int i = 0; i < 6; i++) mst.bit_io(1'b0, k);
        mst.stop();
        chk(serial_image, 64'h8877_6655_44EE_2211);
    endtask
    task automatic t_busy_recall;
        cmd_busy = 1'b1;
        mst.start();
        mst.wr_byte({TA, 1'b0}, k);
        chk(k, 1'b0);
        mst.stop();
        cmd_busy = 1'b0;
        recall_mem_ctrl = 8'h01;
        recall_serial = 64'h0102_0304_0506_0708;
        recall_valid = 1'b1;
        @(negedge ref_clk);
        recall_valid = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(serial_lock_bit, 1'b1);
        rnd_chk(NVCR_OFS_SERIAL_LAST, '{8'h01, ID[31:24]});
    endtask

    initial begin
        rst_n = 1'b0;
        cmd_busy = 1'b0;
        recall_valid = 1'b0;
        recall_mem_ctrl = 8'h00;
        recall_serial = 64'h0;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        t_reset();
        t_serial();
        t_bad();
        t_cmd();
        t_lock();
        t_busy_recall();
        complete_run();
    end
endmodule // nvcr_ctrl_target_bench
`default_nettype wire

// File: nvcr_ctrl_target_properties.sv
// Assertion checker for the control-register target
`timescale 1ns/1ps
`default_nettype none
module nvcr_ctrl_target_properties
    import nvcr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bus and command
    input wire logic scl_i,
    input wire logic sda_oe,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_valid,
    // Images
    input wire logic recall_valid,
    input wire logic [7:0] recall_mem_ctrl,
    input wire logic [63:0] recall_serial,
    input wire logic [7:0] mem_ctrl_image,
    input wire logic [63:0] serial_image,
    input wire logic serial_lock_bit
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ********************************************************************
    // Properties
    // ********************************************************************
    property p_lock_mirror;
        serial_lock_bit == mem_ctrl_image[NVCR_LOCK_BIT];
    endproperty
    a_lock_mirror: assert property (p_lock_mirror)
        else $error("lock bit differs from control image");
    // Two cycles of lock so a same-edge unlock cannot mask a write
    property p_serial_frozen;
        serial_lock_bit && $past(serial_lock_bit) && !recall_valid
            && !$past(recall_valid) |=> $stable(serial_image);
    endproperty
    a_serial_frozen: assert property (p_serial_frozen)
        else $error("serial bytes changed while locked");
    property p_cmd_pulse;
        cmd_valid |=> !cmd_valid;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse)
        else $error("command strobe longer than one cycle");
    property p_cmd_hold;
        $changed(cmd_byte) |-> cmd_valid;
    endproperty
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("command byte changed without strobe");
    property p_cmd_bit8;
        cmd_valid |-> scl_i;
    endproperty
    a_cmd_bit8: assert property (p_cmd_bit8)
        else $error("command strobe outside the eighth clock high");
    property p_img_bit8;
        $changed({mem_ctrl_image, serial_image}) |->
            scl_i || $past(recall_valid) || $past(recall_valid, 2);
    endproperty
    a_img_bit8: assert property (p_img_bit8)
        else $error("register changed away from a data bit");
    property p_recall_load;
        recall_valid |-> ##2 (serial_image == $past(recall_serial, 2)
            && mem_ctrl_image == $past(recall_mem_ctrl, 2));
    endproperty
    a_recall_load: assert property (p_recall_load)
        else $error("restored image not loaded");
    property p_sda_steady;
        scl_i && $past(scl_i) |-> $stable(sda_oe);
    endproperty
    a_sda_steady: assert property (p_sda_steady)
        else $error("data line moved while clock high");
endmodule // nvcr_ctrl_target_properties

bind nvcr_ctrl_target nvcr_ctrl_target_properties u_props (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_oe(sda_oe),
    .cmd_byte(cmd_byte),
    .cmd_valid(cmd_valid),
    .recall_valid(recall_valid),
    .recall_mem_ctrl(recall_mem_ctrl),
    .recall_serial(recall_serial),
    .mem_ctrl_image(mem_ctrl_image),
    .serial_image(serial_image),
    .serial_lock_bit(serial_lock_bit)
);
`default_nettype wire

// File: nvcr_i2c_master.sv
// Behavioural bus master driving the control-register target
`timescale 1ns/1ps
`default_nettype none
module nvcr_i2c_master
#(
    parameter int HALF = 8
) (
    // Clock
    input wire logic ref_clk,
    // Bus lines
    input wire logic sda,
    output var logic scl,
    output var logic sda_pull
);
    // Clock idles high outside frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Data moves only mid-low, well clear of the filtered clock fall
    task automatic bit_io(input logic b, output logic r);
        sda_pull = !b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        r = sda;
        scl = 1'b0;
        tick(HALF);
    endtask
    // Also serves as repeated start after an address phase
    task automatic start;
        sda_pull = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_pull = 1'b1;
        tick(HALF);
        scl = 1'b0;
        tick(HALF);
    endtask
    task automatic stop;
        sda_pull = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_pull = 1'b0;
        tick(4 * HALF);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!more, r);
    endtask
endmodule // nvcr_i2c_master
`default_nettype wire

// File: nvcr_pkg.sv
// Package of constants for the serial-memory control-register target
package nvcr_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0] NVCR_OFS_MEM_CTRL = 8'h00;
    localparam logic [7:0] NVCR_OFS_SERIAL_FIRST = 8'h01;
    localparam logic [7:0] NVCR_OFS_SERIAL_LAST = 8'h08;
    localparam logic [7:0] NVCR_OFS_ID_FIRST = 8'h09;
    localparam logic [7:0] NVCR_OFS_ID_LAST = 8'h0C;
    localparam logic [7:0] NVCR_OFS_CMD = 8'hAA;
    localparam logic [7:0] NVCR_OFS_LAST_READABLE = NVCR_OFS_ID_LAST;
    localparam int NVCR_SERIAL_BYTES = 8;

    // ********************************************************************
    // Field layout
    // ********************************************************************
    localparam int NVCR_LOCK_BIT = 0;
    localparam int NVCR_ID_MAKER_POS = 21;
    localparam int NVCR_ID_PART_POS = 7;
    localparam int NVCR_ID_CAP_POS = 3;
    localparam int NVCR_ID_REV_POS = 0;
    localparam int NVCR_MAKER_BANK_POS = 8;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] NVCR_RST_MEM_CTRL = 8'h00;
    localparam logic [7:0] NVCR_RST_SERIAL = 8'h00;
    localparam logic [7:0] NVCR_RST_PTR = 8'h00;

    // ********************************************************************
    // Bus framing
    // ********************************************************************
    localparam logic [3:0] NVCR_BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] NVCR_BIT_ACK = 4'h8;
    localparam logic [3:0] NVCR_BIT_END = 4'h9;

    // Byte phases, one-hot
    typedef enum logic [5:0] {
        NVCR_ST_IDLE = 6'b00_0001,
        NVCR_ST_DEV = 6'b00_0010,
        NVCR_ST_ADDR = 6'b00_0100,
        NVCR_ST_WR = 6'b00_1000,
        NVCR_ST_RD = 6'b01_0000,
        NVCR_ST_SKIP = 6'b10_0000
    } nvcr_state_t;

endpackage
